// [dv/cfg_fuse_props.sv]
// Checker for the configuration decode and identity block.
// Assumes one clock domain and the package constants.
`timescale 1ns/100ps
module cfg_fuse_props
#(
	parameter logic [23:0] PART_ID = 24'h000000
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic prog_mode,
	input wire logic rd_req,
	input wire logic [23:0] rd_addr,
	input wire logic wr_req,
	input wire logic cfg_ready,
	input wire logic watchdog_windowed,
	input wire logic [3:0] watchdog_window_eighths,
	input wire logic scan_port_en,
	input wire logic [3:0] boot_partition_mode_onehot,
	input wire logic rd_valid,
	input wire logic [23:0] rd_data,
	input wire logic wr_ack,
	input wire logic wr_refused
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence rd_take;
		rd_req && cfg_ready;
	endsequence
	sequence wr_take;
		wr_req && cfg_ready;
	endsequence
	a_read_answer: assert property (rd_take |-> ##2 rd_valid)
		else $error("read not answered");
	a_read_cause: assert property (rd_valid |-> $past(rd_req && cfg_ready, 2))
		else $error("read answer without request");
	a_id_word: assert property (rd_take ##0 rd_addr == cfg_fuse_pkg::ADDR_PART_ID |-> ##2 rd_data == PART_ID)
		else $error("identifier word wrong");
	a_write_ack: assert property (wr_take |=> wr_ack)
		else $error("write not acknowledged");
	a_run_refused: assert property (wr_take ##0 !prog_mode |=> wr_ack && wr_refused)
		else $error("run time write accepted");
	a_window_full: assert property (cfg_ready && !watchdog_windowed |-> watchdog_window_eighths == 4'h8)
		else $error("non-windowed width wrong");
	a_fuse_hold: assert property (cfg_ready && $past(cfg_ready) |-> $stable(scan_port_en))
		else $error("scan enable changed after load");
	a_boot_onehot: assert property (cfg_ready |-> $onehot(boot_partition_mode_onehot))
		else $error("boot mode not one-hot");
endmodule
bind config_fuse_decode_and_id cfg_fuse_props #(.PART_ID(PART_ID)) chk_u (.clk(clk), .sys_rst(sys_rst),
	.prog_mode(prog_mode), .rd_req(rd_req), .rd_addr(rd_addr), .wr_req(wr_req), .cfg_ready(cfg_ready),
	.watchdog_windowed(watchdog_windowed), .watchdog_window_eighths(watchdog_window_eighths),
	.scan_port_en(scan_port_en), .boot_partition_mode_onehot(boot_partition_mode_onehot),
	.rd_valid(rd_valid), .rd_data(rd_data), .wr_ack(wr_ack), .wr_refused(wr_refused));

// [dv/tb_top.sv]
// Self-checking bench for the configuration decode block.
// Assumes default identity parameters and one 50 MHz clock.
`timescale 1ns/100ps
module tb_top;
	logic clk = 0, sys_rst = 1, prog_mode = 0, rd_req = 0, wr_req = 0;
	logic [22:0] fv = 0, kv;
	logic [71:0] tv = 0, kt;
	logic [23:0] rd_addr = 0, wr_addr = 0, wr_data = 0, rd_data, a;
	logic rdy, wd_on, i1, i2, scan, tied, rd_valid, rd_unm, wr_ack, wr_ref;
	logic [3:0] win8, boot;
	logic [2:0] dbg, l1, l2, l3, l4;
	logic [24:0] rq[$];
	logic wq[$];
	logic [23:0] otp_m[64];
	bit wflag[64];
	logic [3:0] wt[4] = '{cfg_fuse_pkg::WIN_75, cfg_fuse_pkg::WIN_50, cfg_fuse_pkg::WIN_37P5, cfg_fuse_pkg::WIN_25};
	logic [23:0] ro[5] = '{cfg_fuse_pkg::ADDR_AMP1_TRIM, cfg_fuse_pkg::ADDR_AMP2_TRIM, cfg_fuse_pkg::ADDR_ISRC_TRIM,
		cfg_fuse_pkg::ADDR_PART_ID, cfg_fuse_pkg::ADDR_PART_REV};
	int miscompares = 0, checks = 0;
	logic [31:0] lfsr_q = 87783;

	always #10 clk = ~clk;

	config_fuse_decode_and_id dut_u (.clk(clk), .sys_rst(sys_rst), .fuse_watchdog_window_size(fv[1:0]),
		.fuse_watchdog_window_disable(fv[2]), .fuse_i2c_port1_pin_map(fv[3]), .fuse_i2c_port2_pin_map(fv[4]),
		.fuse_scan_port_enable(fv[5]), .fuse_debug_channel_select(fv[7:6]), .fuse_dac_cross_connect(fv[8]),
		.fuse_context1_priority(fv[11:9]), .fuse_context2_priority(fv[14:12]), .fuse_context3_priority(fv[17:15]),
		.fuse_context4_priority(fv[20:18]), .fuse_boot_partition_mode(fv[22:21]), .fuse_amp1_trim_word(tv[23:0]),
		.fuse_amp2_trim_word(tv[47:24]), .fuse_current_source_trim_word(tv[71:48]), .prog_mode(prog_mode),
		.rd_req(rd_req), .rd_addr(rd_addr), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .cfg_ready(rdy),
		.watchdog_windowed(wd_on), .watchdog_window_eighths(win8), .i2c1_primary_pins(i1), .i2c2_primary_pins(i2),
		.scan_port_en(scan), .debug_pair_onehot(dbg), .dac_outputs_tied(tied), .context1_interrupt_priority_level(l1),
		.context2_interrupt_priority_level(l2), .context3_interrupt_priority_level(l3),
		.context4_interrupt_priority_level(l4), .boot_partition_mode_onehot(boot), .rd_valid(rd_valid),
		.rd_data(rd_data), .rd_unmapped(rd_unm), .wr_ack(wr_ack), .wr_refused(wr_ref));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [2:0] lv(input logic [2:0] c);
		return (c == 3'h7) ? 3'h0 : c + 3'h1;
	endfunction

	task automatic chk(input logic [24:0] got, input logic [24:0] exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Oldest note answers each result
	always @(posedge clk)
	begin
		if (rd_valid === 1'b1)
			chk({rd_unm, rd_data}, (rq.size() > 0) ? rq.pop_front() : 25'h1FFFFFF);
		if (wr_ack === 1'b1)
			chk(wr_ref, (wq.size() > 0) ? wq.pop_front() : 25'h2);
	end

	task automatic rd(input logic [23:0] ad);
		logic [24:0] e;
		e = 25'h1000000;
		if (ad == ro[0]) e = kt[23:0];
		else if (ad == ro[1]) e = kt[47:24];
		else if (ad == ro[2]) e = kt[71:48];
		else if (ad == ro[3]) e = cfg_fuse_pkg::PART_ID_DEFAULT;
		else if (ad == ro[4]) e = cfg_fuse_pkg::PART_REV_DEFAULT;
		else if ((ad & 24'hFFFF81) == 24'h800F80) e = otp_m[ad[6:1]];
		@(posedge clk);
		rd_req <= 1;
		wr_req <= 0;
		rd_addr <= ad;
		rq.push_back(e);
	endtask

	task automatic wr(input logic p, input logic [23:0] ad, input logic [23:0] d);
		logic ok;
		ok = p && (ad & 24'hFFFF81) == 24'h800F80 && !wflag[ad[6:1]];
		if (ok)
		begin
			otp_m[ad[6:1]] = d;
			wflag[ad[6:1]] = 1;
		end
		@(posedge clk);
		rd_req <= 0;
		wr_req <= 1;
		prog_mode <= p;
		wr_addr <= ad;
		wr_data <= d;
		wq.push_back(!ok);
	endtask

	task automatic dec();
		chk(wd_on, !kv[2]);
		chk(win8, kv[2] ? 4'h8 : wt[kv[1:0]]);
		chk(i1, kv[3]);
		chk(i2, kv[4]);
		chk(scan, kv[5]);
		chk(dbg, (kv[7:6] == 2'h0) ? 3'h0 : 3'h1 << (2'h3 - kv[7:6]));
		chk(tied, !kv[8]);
		chk({l1, l2, l3, l4}, {lv(kv[11:9]), lv(kv[14:12]), lv(kv[17:15]), lv(kv[20:18])});
		chk(boot, 4'h1 << (2'h3 - kv[22:21]));
	endtask

	task automatic round(input int r);
		lfsr_q = lfsr(lfsr_q);
		@(posedge clk);
		sys_rst <= 1;
		fv <= {r[1:0], lfsr_q[20:12], r[2:0], lfsr_q[8], r[1:0], lfsr_q[5:3], r[2], r[1:0]};
		tv <= {lfsr_q[23:0], ~lfsr_q[23:0], lfsr_q[31:8]};
		wflag = '{default: 0};
		repeat (10) @(posedge clk);
		sys_rst <= 0;
		rd_req <= 1;
		rd_addr <= cfg_fuse_pkg::ADDR_PART_ID;
		@(posedge clk);
		rd_req <= 0;
		kv = fv;
		kt = tv;
		fv <= ~fv;
		tv <= ~tv;
		#1 chk(rdy, 1);
		dec();
		a = 24'h800F80 + {lfsr_q[5:0], 1'b0};
		wr(1, a, lfsr_q[31:8]);
		rd(a);
		wr(1, a, ~lfsr_q[31:8]);
		wr(0, 24'h800FFE, lfsr_q[23:0]);
		rd(a + 24'h1);
		rd(24'h801000);
		foreach (ro[i])
		begin
			wr(1, ro[i], lfsr_q[23:0]);
			rd(ro[i]);
		end
		rd(a);
		@(posedge clk);
		rd_req <= 0;
		wr_req <= 0;
		repeat (4) @(posedge clk);
		dec();
	endtask

	initial
	begin
		fork
			begin
				for (int r = 0; r < 8; r++)
					round(r);
				chk(rq.size() + wq.size(), 0);
				end_of_test();
			end
			begin
				repeat (5000) @(posedge clk);
				miscompares++;
				end_of_test();
			end
		join
	end
endmodule

// [logic/cfg_fuse_pkg.sv]
// Constants for the configuration decode and identity block.
// Assumes a single 50 MHz clock and table accesses on 24-bit program addresses.
package cfg_fuse_pkg;

	localparam int ADDR_W = 24;
	localparam int DATA_W = 24;
	localparam int OTP_WORDS = 64;
	localparam int OTP_IDX_W = 6;

	localparam logic [23:0] ADDR_AMP1_TRIM = 24'h800E48;
	localparam logic [23:0] ADDR_AMP2_TRIM = 24'h800E4C;
	localparam logic [23:0] ADDR_ISRC_TRIM = 24'h800E78;
	localparam logic [23:0] ADDR_PART_ID = 24'hFF0000;
	localparam logic [23:0] ADDR_PART_REV = 24'hFF0002;
	localparam logic [23:0] ADDR_OTP_BASE = 24'h800F80;
	localparam logic [23:0] ADDR_OTP_LAST = 24'h800FFE;
	localparam int OTP_IDX_LSB = 1;

	// Arbitrary neutral identity values
	localparam logic [23:0] PART_ID_DEFAULT = 24'h00A5A5;
	localparam logic [23:0] PART_REV_DEFAULT = 24'h000001;

	// Window widths in eighths of the watchdog period
	localparam logic [3:0] WIN_25 = 4'h2;
	localparam logic [3:0] WIN_37P5 = 4'h3;
	localparam logic [3:0] WIN_50 = 4'h4;
	localparam logic [3:0] WIN_75 = 4'h6;
	localparam logic [3:0] WIN_FULL = 4'h8;

	localparam logic [2:0] CTX_RESERVED = 3'h7;
	localparam logic [2:0] CTX_UNASSIGNED = 3'h0;

	localparam logic [2:0] DBG_PAIR1 = 3'h1;
	localparam logic [2:0] DBG_PAIR2 = 3'h2;
	localparam logic [2:0] DBG_PAIR3 = 3'h4;
	localparam logic [2:0] DBG_NONE = 3'h0;

	localparam logic [3:0] BOOT_SINGLE = 4'h1;
	localparam logic [3:0] BOOT_DUAL = 4'h2;
	localparam logic [3:0] BOOT_PROTECTED = 4'h4;
	localparam logic [3:0] BOOT_PRIVILEGED = 4'h8;

	localparam logic [23:0] DATA_RESET = 24'h000000;

	typedef enum logic [0:0]
	{
		ST_LOAD = 1'b0,
		ST_RUN = 1'b1
	} phase_e;

	typedef enum logic [2:0]
	{
		SRC_NONE = 3'b000,
		SRC_AMP1 = 3'b001,
		SRC_AMP2 = 3'b010,
		SRC_ISRC = 3'b011,
		SRC_ID = 3'b100,
		SRC_REV = 3'b101,
		SRC_OTP = 3'b110
	} src_e;

endpackage

// [logic/config_fuse_decode_and_id.sv]
// Configuration field decode, calibration and identity words, and user OTP area.
// Assumes fuse levels stand steady while sys_rst is high and are captured on leaving reset.
`timescale 1ns/100ps
module config_fuse_decode_and_id
#(
	parameter logic [23:0] PART_ID = cfg_fuse_pkg::PART_ID_DEFAULT,
	parameter logic [23:0] PART_REV = cfg_fuse_pkg::PART_REV_DEFAULT
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [1:0] fuse_watchdog_window_size,
	input wire logic fuse_watchdog_window_disable,
	input wire logic fuse_i2c_port1_pin_map,
	input wire logic fuse_i2c_port2_pin_map,
	input wire logic fuse_scan_port_enable,
	input wire logic [1:0] fuse_debug_channel_select,
	input wire logic fuse_dac_cross_connect,
	input wire logic [2:0] fuse_context1_priority,
	input wire logic [2:0] fuse_context2_priority,
	input wire logic [2:0] fuse_context3_priority,
	input wire logic [2:0] fuse_context4_priority,
	input wire logic [1:0] fuse_boot_partition_mode,
	input wire logic [23:0] fuse_amp1_trim_word,
	input wire logic [23:0] fuse_amp2_trim_word,
	input wire logic [23:0] fuse_current_source_trim_word,
	input wire logic prog_mode,
	input wire logic rd_req,
	input wire logic [23:0] rd_addr,
	input wire logic wr_req,
	input wire logic [23:0] wr_addr,
	input wire logic [23:0] wr_data,
	output logic cfg_ready,
	output logic watchdog_windowed,
	output logic [3:0] watchdog_window_eighths,
	output logic i2c1_primary_pins,
	output logic i2c2_primary_pins,
	output logic scan_port_en,
	output logic [2:0] debug_pair_onehot,
	output logic dac_outputs_tied,
	output logic [2:0] context1_interrupt_priority_level,
	output logic [2:0] context2_interrupt_priority_level,
	output logic [2:0] context3_interrupt_priority_level,
	output logic [2:0] context4_interrupt_priority_level,
	output logic [3:0] boot_partition_mode_onehot,
	output logic rd_valid,
	output logic [23:0] rd_data,
	output logic rd_unmapped,
	output logic wr_ack,
	output logic wr_refused
);

	function automatic logic [2:0] ctx_level(input logic [2:0] code);
		if (code == cfg_fuse_pkg::CTX_RESERVED)
		begin
			return cfg_fuse_pkg::CTX_UNASSIGNED;
		end
		return 3'(code + 3'h1);
	endfunction

	function automatic logic otp_hit(input logic [23:0] a);
		return (a >= cfg_fuse_pkg::ADDR_OTP_BASE) && (a <= cfg_fuse_pkg::ADDR_OTP_LAST) && !a[0];
	endfunction

	function automatic logic [5:0] otp_index(input logic [23:0] a);
		logic [23:0] off;
		off = a - cfg_fuse_pkg::ADDR_OTP_BASE;
		return off[cfg_fuse_pkg::OTP_IDX_LSB +: cfg_fuse_pkg::OTP_IDX_W];
	endfunction

	cfg_fuse_pkg::phase_e phase_q, phase_d;

	logic [23:0] amp1_trim_word_q, amp2_trim_word_q, current_source_trim_word_q;
	logic [63:0] otp_written_q, otp_written_d;
	logic rd_pend_q;
	cfg_fuse_pkg::src_e rd_src_q;
	logic [23:0] otp_rd_data;

	// Field decode from the raw fuse levels
	logic [3:0] win_size_w;
	logic [3:0] win_eighths_w;
	logic [2:0] dbg_w;
	logic [3:0] boot_w;

	assign win_size_w = (fuse_watchdog_window_size == 2'b11) ? cfg_fuse_pkg::WIN_25 :
		(fuse_watchdog_window_size == 2'b10) ? cfg_fuse_pkg::WIN_37P5 :
		(fuse_watchdog_window_size == 2'b01) ? cfg_fuse_pkg::WIN_50 : cfg_fuse_pkg::WIN_75;
	assign win_eighths_w = fuse_watchdog_window_disable ? cfg_fuse_pkg::WIN_FULL : win_size_w;
	assign dbg_w = (fuse_debug_channel_select == 2'b11) ? cfg_fuse_pkg::DBG_PAIR1 :
		(fuse_debug_channel_select == 2'b10) ? cfg_fuse_pkg::DBG_PAIR2 :
		(fuse_debug_channel_select == 2'b01) ? cfg_fuse_pkg::DBG_PAIR3 : cfg_fuse_pkg::DBG_NONE;
	assign boot_w = (fuse_boot_partition_mode == 2'b11) ? cfg_fuse_pkg::BOOT_SINGLE :
		(fuse_boot_partition_mode == 2'b10) ? cfg_fuse_pkg::BOOT_DUAL :
		(fuse_boot_partition_mode == 2'b01) ? cfg_fuse_pkg::BOOT_PROTECTED : cfg_fuse_pkg::BOOT_PRIVILEGED;

	// Phase: one load cycle after reset, then run
	logic load_w;
	assign load_w = (phase_q == cfg_fuse_pkg::ST_LOAD);

	always_comb
	begin
		phase_d = phase_q;
		unique case (phase_q)
			cfg_fuse_pkg::ST_LOAD: phase_d = cfg_fuse_pkg::ST_RUN;
			cfg_fuse_pkg::ST_RUN: phase_d = cfg_fuse_pkg::ST_RUN;
		endcase
	end

	// Table read decode
	logic rd_take_w;
	cfg_fuse_pkg::src_e rd_src_w;
	assign rd_take_w = rd_req && !load_w;
	assign rd_src_w = (rd_addr == cfg_fuse_pkg::ADDR_AMP1_TRIM) ? cfg_fuse_pkg::SRC_AMP1 :
		(rd_addr == cfg_fuse_pkg::ADDR_AMP2_TRIM) ? cfg_fuse_pkg::SRC_AMP2 :
		(rd_addr == cfg_fuse_pkg::ADDR_ISRC_TRIM) ? cfg_fuse_pkg::SRC_ISRC :
		(rd_addr == cfg_fuse_pkg::ADDR_PART_ID) ? cfg_fuse_pkg::SRC_ID :
		(rd_addr == cfg_fuse_pkg::ADDR_PART_REV) ? cfg_fuse_pkg::SRC_REV :
		otp_hit(rd_addr) ? cfg_fuse_pkg::SRC_OTP : cfg_fuse_pkg::SRC_NONE;

	// Write gate: only OTP words, only while programming, only once per word between resets
	logic wr_take_w;
	logic wr_otp_w;
	logic [5:0] wr_idx_w;
	logic wr_ok_w;
	assign wr_take_w = wr_req && !load_w;
	assign wr_otp_w = otp_hit(wr_addr);
	assign wr_idx_w = otp_index(wr_addr);
	assign wr_ok_w = wr_take_w && wr_otp_w && prog_mode && !otp_written_q[wr_idx_w];

	always_comb
	begin
		otp_written_d = otp_written_q;
		if (wr_ok_w)
		begin
			otp_written_d[wr_idx_w] = 1'b1;
		end
	end

	otp_word_store u_otp
	(
		.clk(clk),
		.wr_en(wr_ok_w),
		.wr_idx(wr_idx_w),
		.wr_data(wr_data),
		.rd_idx(otp_index(rd_addr)),
		.rd_data(otp_rd_data)
	);

	logic [23:0] rd_mux_w;
	assign rd_mux_w = (rd_src_q == cfg_fuse_pkg::SRC_AMP1) ? amp1_trim_word_q :
		(rd_src_q == cfg_fuse_pkg::SRC_AMP2) ? amp2_trim_word_q :
		(rd_src_q == cfg_fuse_pkg::SRC_ISRC) ? current_source_trim_word_q :
		(rd_src_q == cfg_fuse_pkg::SRC_ID) ? PART_ID :
		(rd_src_q == cfg_fuse_pkg::SRC_REV) ? PART_REV :
		(rd_src_q == cfg_fuse_pkg::SRC_OTP) ? otp_rd_data : cfg_fuse_pkg::DATA_RESET;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			phase_q <= cfg_fuse_pkg::ST_LOAD;
			otp_written_q <= '0;
			rd_pend_q <= 1'b0;
			rd_src_q <= cfg_fuse_pkg::SRC_NONE;
		end
		else
		begin
			phase_q <= phase_d;
			otp_written_q <= otp_written_d;
			rd_pend_q <= rd_take_w;
			rd_src_q <= rd_src_w;
		end
	end

	// Fuse capture during the load cycle
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cfg_ready <= 1'b0;
			watchdog_windowed <= 1'b0;
			watchdog_window_eighths <= cfg_fuse_pkg::WIN_FULL;
			i2c1_primary_pins <= 1'b1;
			i2c2_primary_pins <= 1'b1;
			scan_port_en <= 1'b0;
			debug_pair_onehot <= cfg_fuse_pkg::DBG_NONE;
			dac_outputs_tied <= 1'b0;
			context1_interrupt_priority_level <= cfg_fuse_pkg::CTX_UNASSIGNED;
			context2_interrupt_priority_level <= cfg_fuse_pkg::CTX_UNASSIGNED;
			context3_interrupt_priority_level <= cfg_fuse_pkg::CTX_UNASSIGNED;
			context4_interrupt_priority_level <= cfg_fuse_pkg::CTX_UNASSIGNED;
			boot_partition_mode_onehot <= cfg_fuse_pkg::BOOT_SINGLE;
			amp1_trim_word_q <= cfg_fuse_pkg::DATA_RESET;
			amp2_trim_word_q <= cfg_fuse_pkg::DATA_RESET;
			current_source_trim_word_q <= cfg_fuse_pkg::DATA_RESET;
		end
		else if (load_w)
		begin
			cfg_ready <= 1'b1;
			watchdog_windowed <= !fuse_watchdog_window_disable;
			watchdog_window_eighths <= win_eighths_w;
			i2c1_primary_pins <= fuse_i2c_port1_pin_map;
			i2c2_primary_pins <= fuse_i2c_port2_pin_map;
			scan_port_en <= fuse_scan_port_enable;
			debug_pair_onehot <= dbg_w;
			dac_outputs_tied <= !fuse_dac_cross_connect;
			context1_interrupt_priority_level <= ctx_level(fuse_context1_priority);
			context2_interrupt_priority_level <= ctx_level(fuse_context2_priority);
			context3_interrupt_priority_level <= ctx_level(fuse_context3_priority);
			context4_interrupt_priority_level <= ctx_level(fuse_context4_priority);
			boot_partition_mode_onehot <= boot_w;
			amp1_trim_word_q <= fuse_amp1_trim_word;
			amp2_trim_word_q <= fuse_amp2_trim_word;
			current_source_trim_word_q <= fuse_current_source_trim_word;
		end
	end

	// Read answer two edges after the request; write answer one edge after
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rd_valid <= 1'b0;
			rd_data <= cfg_fuse_pkg::DATA_RESET;
			rd_unmapped <= 1'b0;
			wr_ack <= 1'b0;
			wr_refused <= 1'b0;
		end
		else
		begin
			rd_valid <= rd_pend_q;
			rd_data <= rd_pend_q ? rd_mux_w : cfg_fuse_pkg::DATA_RESET;
			rd_unmapped <= rd_pend_q && (rd_src_q == cfg_fuse_pkg::SRC_NONE);
			wr_ack <= wr_take_w;
			wr_refused <= wr_take_w && !wr_ok_w;
		end
	end

endmodule

// [logic/otp_word_store.sv]
// Word store for the one-time-programmable area.
// Assumes the caller has already decided whether a write is allowed.
`timescale 1ns/100ps
module otp_word_store
#(
	parameter int WORDS = cfg_fuse_pkg::OTP_WORDS,
	parameter int IDX_W = cfg_fuse_pkg::OTP_IDX_W,
	parameter int WIDTH = cfg_fuse_pkg::DATA_W
)
(
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [IDX_W-1:0] wr_idx,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [IDX_W-1:0] rd_idx,
	output logic [WIDTH-1:0] rd_data
);

	logic [WIDTH-1:0] mem [WORDS];

	always_ff @(posedge clk)
	begin
		if (wr_en)
		begin
			mem[wr_idx] <= wr_data;
		end
		rd_data <= mem[rd_idx];
	end

endmodule
